/* File: rtl/duri_debug_serial_unit.sv */
// Register side of the debug serial unit with AHB-Lite slave
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
module duri_debug_serial_unit
    import duri_pkg::*;
#(
    parameter int          CD_W     = 16,
    parameter logic [31:0] CHIP_ID  = 32'h8123_4560,  // Arbitrary value
    parameter logic [31:0] CHIP_EXT = 32'h0000_00a5   // Arbitrary value
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rx_pin,
    output logic             tx_pin,
    input  wire logic        dbg_chan_rx_pending,
    input  wire logic        dbg_chan_tx_pending,
    input  wire logic        rx_dma_end,
    input  wire logic        tx_dma_end,
    input  wire logic        tx_dma_buffer_empty,
    input  wire logic        rx_dma_buffer_full,
    output logic             irq,
    output logic             tap_reset_force
);
    typedef struct packed {
        duri_ph_t          ph;        // Bus data-phase progress
        logic              wr;        // Captured direction
        logic [7:0]        addr;      // Captured offset
        logic [31:0]       rdata;     // Read data register
        logic [2:0]        par;       // parity_select
        logic [1:0]        chm;       // channel_mode_select
        logic [CD_W-1:0]   cd;        // Baud divisor
        logic [CD_W-1:0]   cnt;       // Baud prescaler
        logic [31:0]       imr;       // Interrupt mask
        logic              fnr;       // force_test_reset
        logic              rx_en;
        logic              tx_en;
        logic              tx_off;    // Disable waiting for drain
        logic              thr_full;
        logic [7:0]        thr;
        logic [7:0]        rhr;
        logic              rx_ready_flag;
        logic              overrun_flag;
        logic              frame;
        logic              parity_error_flag;
        logic              tx_load;   // One-cycle load strobe
        logic              tx_rst;    // One-cycle abort strobes
        logic              rx_rst;
    } duri_st_t;

    duri_st_t    q, n;
    duri_ser_if  ser ();
    logic        tick;      // 16x bit-rate strobe
    logic        hit;       // Address phase accepted
    logic        rd_clr;    // Receive holding read this cycle
    logic        err_clr;   // Error flags cleared this cycle
    logic        tx_idle;
    logic [31:0] flags;     // Live status word
    logic [31:0] rd_mux;

    // Serial engines
    duri_tx u_tx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .s       (ser.txp)
    );
    duri_rx u_rx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .s       (ser.rxp)
    );

    // Prescaler tick; divisor zero stops the bit clock
    assign tick = (q.cd != '0) && (q.cnt == q.cd - CD_W'(1));

    // Transmitter idle: enabled, nothing held, nothing shifting
    assign tx_idle = q.tx_en & ~q.thr_full & ~ser.tx_busy & ~q.tx_load;

    // Status word; debug channel flags are wired live, reserved bits zero
    always_comb begin
        flags          = '0;
        flags[S_RX_READY_FLAG] = q.rx_ready_flag;
        flags[S_TX_READY_FLAG] = q.tx_en & ~q.thr_full;
        flags[S_RXEND] = rx_dma_end;
        flags[S_TXEND] = tx_dma_end;
        flags[S_OVR]   = q.overrun_flag;
        flags[S_FRM]   = q.frame;
        flags[S_PAR]   = q.parity_error_flag;
        flags[S_TXIDL] = tx_idle;
        flags[S_TXBE]  = tx_dma_buffer_empty;
        flags[S_RXBF]  = rx_dma_buffer_full;
        flags[S_DTX]   = dbg_chan_tx_pending;
        flags[S_DRX]   = dbg_chan_rx_pending;
    end

    // Read multiplexer; write-only and unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        case (q.addr)
            A_MODE:  begin
                rd_mux[M_PAR_HI:M_PAR_LO] = q.par;
                rd_mux[M_CH_HI:M_CH_LO]   = q.chm;
            end
            A_IMASK: rd_mux = q.imr;
            A_FLAGS: rd_mux = flags;
            A_RHR:   rd_mux[7:0] = q.rhr;
            A_BAUD:  rd_mux[CD_W-1:0] = q.cd;
            A_CID:   rd_mux = CHIP_ID;
            A_CIDX:  rd_mux = CHIP_ID[31] ? CHIP_EXT : '0;
            A_LOCK:  rd_mux[L_FORCE] = q.fnr;
            default: rd_mux = '0;
        endcase
    end

    // Zero-wait address phase, one wait state in the data phase so a read
    // always sees the effect of the write just before it
    assign hreadyout = (q.ph != PH_WAIT);
    assign hit       = hsel & htrans[1] & hready;

    // Next-state logic of the whole block
    always_comb begin
        n         = q;
        n.tx_load = 1'b0;
        n.tx_rst  = 1'b0;
        n.rx_rst  = 1'b0;
        rd_clr    = 1'b0;
        err_clr   = 1'b0;
        n.cnt     = (q.cd == '0 || tick) ? '0 : q.cnt + CD_W'(1);
        // Feed the shifter from the holding register
        if (q.tx_en && q.thr_full && !ser.tx_busy && !q.tx_load) begin
            n.tx_load  = 1'b1;
            n.thr_full = 1'b0;
        end
        // Pending disable takes effect once both stages are empty
        if (q.tx_off && !q.thr_full && !ser.tx_busy && !q.tx_load) begin
            n.tx_en  = 1'b0;
            n.tx_off = 1'b0;
        end
        case (q.ph)
            PH_WAIT: begin
                n.ph    = PH_DONE;
                n.rdata = rd_mux;
                if (!q.wr) begin
                    rd_clr = (q.addr == A_RHR);
                end else begin
                    case (q.addr)
                        A_CMD: begin
                            if (hwdata[C_RXRST]) begin
                                n.rx_en  = 1'b0;
                                n.rx_rst = 1'b1;
                            end else if (hwdata[C_RXOFF]) begin
                                n.rx_en = 1'b0;
                            end else if (hwdata[C_RXON]) begin
                                n.rx_en = 1'b1;
                            end
                            if (hwdata[C_TXRST]) begin
                                n.tx_en    = 1'b0;
                                n.tx_off   = 1'b0;
                                n.thr_full = 1'b0;
                                n.tx_load  = 1'b0;
                                n.tx_rst   = 1'b1;
                            end else if (hwdata[C_TXOFF]) begin
                                // Idle stops at once, else drain first
                                // An already disabled transmitter stays off
                                n.tx_off = q.tx_en & ~tx_idle;
                                n.tx_en  = q.tx_en & ~tx_idle;
                            end else if (hwdata[C_TXON]) begin
                                n.tx_en  = 1'b1;
                                n.tx_off = 1'b0;
                            end
                            err_clr = hwdata[C_ERRCLR];
                        end
                        A_MODE: begin
                            n.par = hwdata[M_PAR_HI:M_PAR_LO];
                            n.chm = hwdata[M_CH_HI:M_CH_LO];
                        end
                        A_IEN:  n.imr = q.imr | (hwdata & IRQ_VALID);
                        A_IDIS: n.imr = q.imr & ~hwdata;
                        A_THR: begin
                            // Characters written while disabled are dropped
                            if (q.tx_en && !q.tx_off) begin
                                n.thr      = hwdata[7:0];
                                n.thr_full = 1'b1;
                            end
                        end
                        A_BAUD: n.cd  = hwdata[CD_W-1:0];
                        A_LOCK: n.fnr = hwdata[L_FORCE];
                        default: n.cd = q.cd;                 // Identity writes ignored
                    endcase
                end
            end
            default: begin
                n.ph = hit ? PH_WAIT : PH_IDLE;
                if (hit) begin
                    n.wr   = hwrite;
                    n.addr = haddr[7:0];
                end
            end
        endcase
        // Receive flags: clears first, so a same-cycle event wins
        if (rd_clr) begin
            n.rx_ready_flag = 1'b0;
        end
        if (err_clr) begin
            n.overrun_flag  = 1'b0;
            n.frame = 1'b0;
            n.parity_error_flag  = 1'b0;
        end
        if (ser.rx_done) begin
            n.rhr   = ser.rx_data;
            n.rx_ready_flag = 1'b1;
            n.overrun_flag  = n.overrun_flag | (q.rx_ready_flag & ~rd_clr);
            n.frame = n.frame | ser.rx_ferr;
            n.parity_error_flag  = n.parity_error_flag | ser.rx_perr;
        end
    end

    // State register; the lock bit comes up clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Engine hookup and channel-mode routing
    assign ser.tick    = tick;
    assign ser.par     = q.par;
    assign ser.tx_load = q.tx_load;
    assign ser.tx_data = q.thr;
    assign ser.tx_rst  = q.tx_rst;
    assign ser.rx_rst  = q.rx_rst;
    // Remote loopback takes the receiver off the line entirely
    assign ser.rx_en   = q.rx_en & (q.chm != CH_REMOTE);
    assign ser.rx_line = (q.chm == CH_LOCAL) ? ser.tx_line :
                         (q.chm == CH_REMOTE) ? 1'b1 : rx_pin;

    // Output pin: echo and remote pass the input through bit by bit
    always_comb begin
        case (q.chm)
            CH_NORMAL: tx_pin = ser.tx_line;
            CH_LOCAL:  tx_pin = 1'b1;
            default:   tx_pin = rx_pin;
        endcase
    end

    assign irq             = |(flags & q.imr);
    assign tap_reset_force = q.fnr;
    assign hresp           = 1'b0;
    assign hrdata          = q.rdata;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic rd_done;
    assign rd_done = (q.ph == PH_DONE) && !q.wr;

    property p_drx_bit;
        rd_done && q.addr == A_FLAGS |-> hrdata[S_DRX] == $past(dbg_chan_rx_pending);
    endproperty
    a_drx_bit: assert property (p_drx_bit) else $error("rx pending bit wrong");

    property p_dtx_bit;
        rd_done && q.addr == A_FLAGS |-> hrdata[S_DTX] == $past(dbg_chan_tx_pending);
    endproperty
    a_dtx_bit: assert property (p_dtx_bit) else $error("tx pending bit wrong");

    property p_cid_fixed;
        rd_done && q.addr == A_CID |-> hrdata == CHIP_ID;
    endproperty
    a_cid_fixed: assert property (p_cid_fixed) else $error("chip id changed");

    property p_cidx;
        rd_done && q.addr == A_CIDX |-> hrdata == (CHIP_ID[31] ? CHIP_EXT : 32'h0000_0000);
    endproperty
    a_cidx: assert property (p_cidx) else $error("extension id wrong");

    property p_lock;
        q.ph == PH_WAIT && q.wr && q.addr == A_LOCK |=> tap_reset_force == $past(hwdata[0]);
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit not taken");

    property p_rx_abort;
        q.ph == PH_WAIT && q.wr && q.addr == A_CMD && hwdata[C_RXRST]
            |=> !q.rx_en ##1 !ser.rx_busy;
    endproperty
    a_rx_abort: assert property (p_rx_abort) else $error("receiver not aborted");

    property p_rx_on;
        q.ph == PH_WAIT && q.wr && q.addr == A_CMD && hwdata[C_RXON]
            |=> q.rx_en == !$past(hwdata[C_RXOFF] | hwdata[C_RXRST]);
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("receiver enable wrong");

    property p_err_clr;
        q.ph == PH_WAIT && q.wr && q.addr == A_CMD && hwdata[C_ERRCLR] && !ser.rx_done
            |=> !q.overrun_flag && !q.frame && !q.parity_error_flag && q.rx_ready_flag == $past(q.rx_ready_flag);
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error flags not cleared");

    property p_mask_rw;
        q.ph == PH_WAIT && q.wr && (q.addr == A_IEN || q.addr == A_IDIS)
            |=> q.imr == ($past(q.addr) == A_IEN ? ($past(q.imr) | ($past(hwdata) & IRQ_VALID))
                                                 : ($past(q.imr) & ~$past(hwdata)));
    endproperty
    a_mask_rw: assert property (p_mask_rw) else $error("mask update wrong");

    property p_tx_drain;
        q.tx_en && !q.tx_off && q.ph == PH_WAIT && q.wr && q.addr == A_CMD
            && hwdata[C_TXOFF] && !hwdata[C_TXRST] && ser.tx_busy |=> q.tx_en [*2];
    endproperty
    a_tx_drain: assert property (p_tx_drain) else $error("disable cut a character");

    property p_irq;
        q.imr[S_DRX] && dbg_chan_rx_pending |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("debug irq missing");
endmodule

/* File: rtl/duri_pkg.sv */
// Shared constants and types of the debug serial unit
package duri_pkg;
    // Register byte offsets within the 256-byte window
    localparam logic [7:0] A_CMD   = 8'h00;
    localparam logic [7:0] A_MODE  = 8'h04;
    localparam logic [7:0] A_IEN   = 8'h08;
    localparam logic [7:0] A_IDIS  = 8'h0c;
    localparam logic [7:0] A_IMASK = 8'h10;
    localparam logic [7:0] A_FLAGS = 8'h14;
    localparam logic [7:0] A_RHR   = 8'h18;
    localparam logic [7:0] A_THR   = 8'h1c;
    localparam logic [7:0] A_BAUD  = 8'h20;
    localparam logic [7:0] A_CID   = 8'h40;
    localparam logic [7:0] A_CIDX  = 8'h44;
    localparam logic [7:0] A_LOCK  = 8'h48;
    // Command bits
    localparam int C_RXRST = 2;
    localparam int C_TXRST = 3;
    localparam int C_RXON  = 4;
    localparam int C_RXOFF = 5;
    localparam int C_TXON  = 6;
    localparam int C_TXOFF = 7;
    localparam int C_ERRCLR = 8;
    // Mode fields
    localparam int M_PAR_LO = 9;
    localparam int M_PAR_HI = 11;
    localparam int M_CH_LO  = 14;
    localparam int M_CH_HI  = 15;
    localparam int L_FORCE  = 0;
    // Status and interrupt bit positions
    localparam int S_RX_READY_FLAG = 0;
    localparam int S_TX_READY_FLAG = 1;
    localparam int S_RXEND = 3;
    localparam int S_TXEND = 4;
    localparam int S_OVR   = 5;
    localparam int S_FRM   = 6;
    localparam int S_PAR   = 7;
    localparam int S_TXIDL = 9;
    localparam int S_TXBE  = 11;
    localparam int S_RXBF  = 12;
    localparam int S_DTX   = 30;
    localparam int S_DRX   = 31;
    localparam logic [31:0] IRQ_VALID = 32'hc000_1afb;
    // Parity and channel encodings
    localparam logic [2:0] PAR_EVEN  = 3'h0;
    localparam logic [2:0] PAR_ODD   = 3'h1;
    localparam logic [2:0] PAR_SPACE = 3'h2;
    localparam logic [1:0] CH_NORMAL = 2'h0;
    localparam logic [1:0] CH_ECHO   = 2'h1;
    localparam logic [1:0] CH_LOCAL  = 2'h2;
    localparam logic [1:0] CH_REMOTE = 2'h3;
    // Frame timing: tick positions in 16x ticks, frame lengths in bits
    localparam logic [3:0] TICK_LAST  = 4'hf;
    localparam logic [3:0] START_LAST = 4'h7;
    localparam logic [3:0] TX_BITS     = 4'ha;
    localparam logic [3:0] TX_BITS_PAR = 4'hb;
    localparam logic [3:0] RX_BITS     = 4'h9;
    localparam logic [3:0] RX_BITS_PAR = 4'ha;
    // Bus phase, Gray along idle-wait-done
    typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_WAIT = 2'b01, PH_DONE = 2'b11} duri_ph_t;
    // Parity bit for a character under the selected parity type
    function automatic logic duri_parity(input logic [2:0] sel, input logic [7:0] d);
        case (sel[1:0])
            PAR_EVEN[1:0]:  duri_parity = ^d;
            PAR_ODD[1:0]:   duri_parity = ~^d;
            PAR_SPACE[1:0]: duri_parity = 1'b0;
            default:        duri_parity = 1'b1;
        endcase
    endfunction
endpackage

/* File: rtl/duri_rx.sv */
// Receiver: start filter of 8 low ticks, mid-bit sampling
`timescale 1ns/100ps
module duri_rx
    import duri_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    duri_ser_if.rxp  s
);
    typedef struct packed {
        logic       busy;
        logic [3:0] lowc;  // Low ticks seen while hunting
        logic [3:0] sub;
        logic [3:0] nb;
        logic [9:0] sh;
        logic       done;
        logic [7:0] data;
        logic       perr;
        logic       ferr;
    } duri_rx_t;
    duri_rx_t q, n;
    logic [9:0] fr;

    // Once a start is taken the character runs to its stop bit even if
    // the enable drops; only the abort strobe cuts it short
    always_comb begin
        n      = q;
        n.done = 1'b0;
        fr     = {s.rx_line, q.sh[9:1]};
        if (s.rx_rst) begin
            n = '0;
        end else if (!q.busy) begin
            if (s.tick) begin
                n.lowc = '0;
                if (s.rx_en && !s.rx_line) begin
                    n.lowc = q.lowc + 4'h1;
                    if (q.lowc == START_LAST) begin
                        n.busy = 1'b1;
                        n.sub  = '0;
                        n.nb   = s.par[2] ? RX_BITS : RX_BITS_PAR;
                    end
                end
            end
        end else if (s.tick) begin
            n.sub = q.sub + 4'h1;
            if (q.sub == TICK_LAST) begin
                n.sh = fr;
                n.nb = q.nb - 4'h1;
                if (q.nb == 4'h1) begin
                    n.busy = 1'b0;
                    n.lowc = '0;
                    n.done = 1'b1;
                    n.data = s.par[2] ? fr[8:1] : fr[7:0];
                    n.ferr = ~fr[9];
                    n.perr = ~s.par[2] & (fr[8] != duri_parity(s.par, fr[7:0]));
                end
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign s.rx_busy = q.busy;
    assign s.rx_done = q.done;
    assign s.rx_data = q.data;
    assign s.rx_perr = q.perr;
    assign s.rx_ferr = q.ferr;
endmodule

/* File: rtl/duri_ser_if.sv */
// Control and data between the register side and the serial engines
`timescale 1ns/100ps
interface duri_ser_if;
    logic       tick;     // 16x bit-rate strobe
    logic [2:0] par;      // Parity type
    logic       tx_load;  // Take tx_data into the shifter
    logic [7:0] tx_data;
    logic       tx_rst;   // Abort transmitter
    logic       tx_busy;
    logic       tx_line;
    logic       rx_rst;   // Abort receiver
    logic       rx_en;
    logic       rx_line;
    logic       rx_busy;
    logic       rx_done;  // One-cycle character strobe
    logic [7:0] rx_data;
    logic       rx_perr;
    logic       rx_ferr;
    modport ctl (output tick, par, tx_load, tx_data, tx_rst, rx_rst, rx_en, rx_line,
                 input tx_busy, tx_line, rx_busy, rx_done, rx_data, rx_perr, rx_ferr);
    modport txp (input tick, par, tx_load, tx_data, tx_rst, output tx_busy, tx_line);
    modport rxp (input tick, par, rx_rst, rx_en, rx_line,
                 output rx_busy, rx_done, rx_data, rx_perr, rx_ferr);
endinterface

/* File: rtl/duri_tx.sv */
// Transmit shifter: start, 8 data LSB first, optional parity, stop
`timescale 1ns/100ps
module duri_tx
    import duri_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    duri_ser_if.txp  s
);
    typedef struct packed {
        logic        busy;
        logic [3:0]  sub;   // Tick within the bit
        logic [3:0]  nb;    // Bits left
        logic [10:0] sh;    // Frame, LSB on the line
    } duri_tx_t;
    duri_tx_t q, n;

    // Abort wins over load so a reset command never leaks a character
    always_comb begin
        n = q;
        if (s.tx_rst) begin
            n = '0;
        end else if (s.tx_load) begin
            n.busy = 1'b1;
            n.sub  = '0;
            n.nb   = s.par[2] ? TX_BITS : TX_BITS_PAR;
            n.sh   = {1'b1, (s.par[2] | duri_parity(s.par, s.tx_data)), s.tx_data, 1'b0};
        end else if (q.busy && s.tick) begin
            n.sub = q.sub + 4'h1;
            if (q.sub == TICK_LAST) begin
                n.sh = {1'b1, q.sh[10:1]};
                n.nb = q.nb - 4'h1;
                if (q.nb == 4'h1) begin
                    n.busy = 1'b0;
                end
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign s.tx_busy = q.busy;
    assign s.tx_line = ~q.busy | q.sh[0];  // Idle line is mark
endmodule

/* File: test/duri_term.sv */
// Serial terminal model on the unit's receive and transmit lines
`timescale 1ns/100ps
module duri_term (
    input wire logic hclk,
    input wire logic txd,
    output logic     line
);
    initial line = 1'b1; // Idle at mark
    // Start, 8 data LSB first, even parity, stop; n clocks a bit
    task automatic send(input logic [7:0] b, input int n);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            repeat (n) @(posedge hclk);
        end
    endtask
    // Collects one frame from the unit's transmit line, sampled mid-bit
    task automatic recv(output logic [10:0] f, input int n);
        do @(negedge hclk); while (txd !== 1'b0);
        repeat (n / 2 - 1) @(negedge hclk);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd;
            repeat (n) @(negedge hclk);
        end
    endtask
endmodule

/* File: test/test_debug_uart_register_interface.sv */
// Self-checking bench of the debug serial unit
`timescale 1ns/100ps
module test_debug_uart_register_interface
    import duri_pkg::*;
;
    localparam logic [31:0] CID = 32'h8000_0011; // Arbitrary value
    localparam logic [31:0] CEX = 32'h0000_0022; // Arbitrary value
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
    logic drx = 1'b0, dtx = 1'b0, rx_pin, tx_pin, hreadyout, hresp, irq, tap_reset_force;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v, w;
    logic [31:0] rq[$], mq[$]; // Expected read data and compare masks
    logic [10:0] f;            // Frame seen on the transmit line
    int error_cnt = 0, tests_run = 0;
    always #10 hclk = ~hclk;
    duri_debug_serial_unit #(.CHIP_ID(CID), .CHIP_EXT(CEX)) i_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .dbg_chan_rx_pending(drx), .dbg_chan_tx_pending(dtx), .rx_dma_end(1'b0),
        .tx_dma_end(1'b0), .tx_dma_buffer_empty(1'b0), .rx_dma_buffer_full(1'b0),
        .irq(irq), .tap_reset_force(tap_reset_force));
    duri_term i_term (.hclk(hclk), .txd(tx_pin), .line(rx_pin));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    // One single transfer; hready is judged just before each rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsel <= 1'b1;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        if (!wr) begin
            rq.push_back(d & m);
            mq.push_back(m);
            rd_pend <= 1'b1;
        end
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        rd_pend <= 1'b0;
        hsel <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        bus(1'b0, a, e, m);
    endtask
    // Watches the data phase end and compares with the oldest note
    always @(negedge hclk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            chk("hrdata", rq.pop_front(), hrdata & mq.pop_front());
            chk("hresp", 32'h0, {31'h0, hresp});
        end
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        v = $urandom(93);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(A_IMASK, 0);
        rd(A_LOCK, 0);
        wr(A_CID, 0);
        wr(A_CIDX, 0);
        rd(A_CID, CID);
        rd(A_CIDX, CEX);
        rd(8'h24, 0);
        wr(A_LOCK, 1);
        chk("tap_reset_force", 1, {31'h0, tap_reset_force});
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(A_LOCK, 0);
        chk("tap_reset_force", 0, {31'h0, tap_reset_force});
        v = $urandom;
        wr(A_MODE, v);
        rd(A_MODE, v & 32'h0000_ce00);
        wr(A_MODE, 0);
        wr(A_IEN, v);
        rd(A_IMASK, v & IRQ_VALID);
        w = $urandom;
        wr(A_IDIS, w);
        rd(A_IMASK, v & ~w & IRQ_VALID);
        wr(A_IDIS, '1);
        wr(A_IEN, 32'h8000_0000);
        drx <= 1'b1;
        dtx <= 1'b1;
        @(negedge hclk);
        chk("irq", 1, {31'h0, irq});
        rd(A_FLAGS, 32'hc000_0000, 32'hc000_0000);
        wr(A_IDIS, 32'h8000_0000);
        chk("irq", 0, {31'h0, irq});
        wr(A_BAUD, 1);
        wr(A_CMD, 32'h10);
        i_term.send(w[7:0], 16);
        repeat (30) @(posedge hclk);
        rd(A_FLAGS, 1, 1);
        rd(A_RHR, {24'h0, w[7:0]});
        rd(A_FLAGS, 0, 1);
        wr(A_CMD, 32'h40);
        fork
            i_term.recv(f, 16);
            begin
                wr(A_THR, {24'h0, w[15:8]});
                wr(A_CMD, 32'h80);
            end
        join
        chk("tx frame", {21'h0, 1'b1, ^w[15:8], w[15:8], 1'b0}, {21'h0, f});
        rd(A_FLAGS, 0, 32'h0000_0202);
        wr(A_THR, 32'h55);
        repeat (40) @(negedge hclk);
        chk("tx_pin", 1, {31'h0, tx_pin});
        wr(A_MODE, 32'h0000_0200);
        i_term.send(8'h01, 16);
        i_term.send(8'h02, 16);
        rd(A_FLAGS, 32'h0000_00a1, 32'h0000_00e1);
        wr(A_CMD, 32'h100);
        rd(A_FLAGS, 1, 32'h0000_00e1);
        rd(A_RHR, 2);
        wr(A_MODE, 0);
        fork
            i_term.send(8'h3c, 16);
            begin
                repeat (60) @(posedge hclk);
                wr(A_CMD, 32'h20);
            end
        join
        rd(A_RHR, 32'h3c);
        wr(A_CMD, 32'h10);
        fork
            i_term.send(8'h5a, 16);
            begin
                repeat (60) @(posedge hclk);
                wr(A_CMD, 32'h04);
            end
        join
        rd(A_FLAGS, 0, 1);
        wr(A_MODE, 32'h0000_8000);
        wr(A_CMD, 32'h50);
        wr(A_THR, {24'h0, w[23:16]});
        repeat (100) @(negedge hclk);
        chk("tx_pin", 1, {31'h0, tx_pin});
        repeat (100) @(posedge hclk);
        rd(A_RHR, {24'h0, w[23:16]});
        give_verdict;
    end
    initial begin
        repeat (4000) @(posedge hclk);
        error_cnt++;
        give_verdict;
    end
endmodule
